// [logic/pb_pkg.sv]
// Purpose: Constants for the power button and power state interrupt block
// Assumes: 50 MHz system clock, APB register access, one word per register
// Notes: Register indices are word indices; byte address is four times one
package pb_pkg;

    localparam int CLK_HZ = 50_000_000;
    // Hold timeout unit, in seconds, and its cycle count
    localparam int HOLD_UNIT_S = 1;
    localparam int HOLD_UNIT_CYCLES = HOLD_UNIT_S * CLK_HZ;
    // Debounce settle time, in milliseconds, and its cycle count
    localparam int DEBOUNCE_MS = 10;
    localparam int DEBOUNCE_CYCLES = DEBOUNCE_MS * (CLK_HZ / 1000);

    // Register word indices
    localparam logic [14:0] IDX_CTRL = 15'h4005;
    localparam logic [14:0] IDX_SEC = 15'h4007;
    localparam logic [14:0] IDX_OFFSRC = 15'h4009;
    localparam logic [14:0] IDX_STAT1 = 15'h4011;
    localparam logic [14:0] IDX_STAT2 = 15'h4012;
    localparam logic [14:0] IDX_MASK1 = 15'h4019;
    localparam logic [14:0] IDX_MASK2 = 15'h401a;

    // Field positions
    localparam int CTRL_TO_LSB = 0;
    localparam int CTRL_STS_BIT = 3;
    localparam int CTRL_PRI_LSB = 4;
    localparam int CTRL_SEC_LSB = 8;
    localparam int BTN_FLAG_BIT = 12;
    localparam int POR_BIT = 2;
    localparam int SLPOFF_BIT = 1;
    localparam int ONWAKE_BIT = 0;
    localparam int OFFSRC_BTN_BIT = 4;

    // Reset values
    localparam logic [1:0] TO_RST = 2'h0;
    localparam logic [1:0] PRI_RST = 2'h0;
    localparam logic [1:0] SEC_RST = 2'h1;
    localparam logic BTN_MASK_RST = 1'b1;
    localparam logic [2:0] PS_MASK_RST = 3'h7;

    // Action codes; code 0 means ignore (primary) or interrupt (secondary)
    localparam logic [1:0] ACT_ZERO = 2'h0;
    localparam logic [1:0] ACT_ON = 2'h1;
    localparam logic [1:0] ACT_OFF = 2'h2;

    // Security unlock value; arbitrary
    localparam logic [15:0] UNLOCK_CODE = 16'h9e4b;

    typedef enum logic [3:0] {
        HOLD_IDLE = 4'h1,
        HOLD_PRI = 4'h2,
        HOLD_SEC = 4'h4,
        HOLD_TER = 4'h8
    } pb_hold_t;

endpackage

// [logic/pb_power_button.sv]
// Purpose: Power button actions, power state flags and APB registers
// Assumes: Button and state inputs are synchronous to clk_sys
// Notes: APB answers with one wait state; all outputs are registered
`timescale 1ns/1ns
module pb_power_button
    import pb_pkg::*;
#(
    parameter int ONE_SEC_CYCLES = HOLD_UNIT_CYCLES,
    parameter int DEB_CYCLES = DEBOUNCE_CYCLES
)
(
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [16:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic button_n,
    input wire logic state_on,
    input wire logic state_sleep,
    input wire logic state_off,
    input wire logic por_event,
    output logic on_req,
    output logic off_req,
    output logic power_state_irq,
    output logic button_irq,
    output logic gpio_on_ind,
    output logic gpio_sleep_ind
);

    logic [31:0] deb_cnt_q;
    logic btn_db_q;
    logic btn_raw_q;
    logic [31:0] pre_cnt_q;
    logic [4:0] sec_cnt_q;
    pb_hold_t hold_q;
    logic [1:0] timeout_q;
    logic [1:0] button_primary_action;
    logic [1:0] button_secondary_action;
    logic unlocked_q;
    logic button_edge_flag;
    logic button_edge_mask;
    logic por_event_flag;
    logic sleep_off_event_flag;
    logic on_wake_event_flag;
    logic por_event_mask;
    logic sleep_off_event_mask;
    logic on_wake_event_mask;
    logic on_prev_q;
    logic slpoff_prev_q;
    logic off_prev_q;
    logic por_prev_q;
    logic btn_off_pend_q;
    logic offsrc_btn_q;
    logic on_req_q;
    logic off_req_q;
    logic ps_irq_q;
    logic btn_irq_q;
    logic gpio_on_q;
    logic gpio_sleep_q;
    logic pready_q;
    logic pslverr_q;
    logic [31:0] prdata_q;

    logic [14:0] idx;
    logic access;
    logic wr_en;
    logic hit_ctrl;
    logic hit_stat1;
    logic hit_stat2;
    logic mapped;
    logic press;
    logic release_ev;
    logic sec_tick;
    logic [4:0] period;
    logic sec_fire;
    logic ter_fire;
    logic on_d;
    logic off_d;
    logic sec_irq_d;
    logic [31:0] rd_val;

    assign idx = paddr[16:2];
    assign access = psel & penable;
    assign wr_en = access & pready_q & pwrite;
    assign hit_ctrl = idx == IDX_CTRL;
    assign hit_stat1 = idx == IDX_STAT1;
    assign hit_stat2 = idx == IDX_STAT2;
    assign mapped = (paddr[1:0] == 2'h0) &&
        (hit_ctrl || hit_stat1 || hit_stat2 || idx == IDX_SEC ||
         idx == IDX_OFFSRC || idx == IDX_MASK1 || idx == IDX_MASK2);

    // Debounce: the raw level must hold steady for the full settle time
    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            btn_raw_q <= 1'b1;
            btn_db_q <= 1'b1;
            deb_cnt_q <= 32'h0;
        end
        else
        begin
            btn_raw_q <= button_n;
            if (btn_raw_q == btn_db_q)
                deb_cnt_q <= 32'h0;
            else if (deb_cnt_q == 32'(DEB_CYCLES - 1))
            begin
                btn_db_q <= btn_raw_q;
                deb_cnt_q <= 32'h0;
            end
            else
                deb_cnt_q <= deb_cnt_q + 32'h1;
        end
    end

    // Debounced low means pressed
    assign press = btn_db_q & ~btn_raw_q & (deb_cnt_q == 32'(DEB_CYCLES - 1));
    assign release_ev = ~btn_db_q & btn_raw_q &
        (deb_cnt_q == 32'(DEB_CYCLES - 1));

    assign sec_tick = pre_cnt_q == 32'(ONE_SEC_CYCLES - 1);
    assign period = 5'h1 << timeout_q;
    assign sec_fire = (hold_q == HOLD_PRI) && (sec_cnt_q == period);
    assign ter_fire = (hold_q == HOLD_SEC) &&
        (sec_cnt_q == 5'(period << 1));

    // Hold timer; restarts from zero at every press
    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            hold_q <= HOLD_IDLE;
            pre_cnt_q <= 32'h0;
            sec_cnt_q <= 5'h0;
        end
        else if (press || release_ev)
        begin
            hold_q <= press ? HOLD_PRI : HOLD_IDLE;
            pre_cnt_q <= 32'h0;
            sec_cnt_q <= 5'h0;
        end
        else
        begin
            unique case (hold_q)
                HOLD_IDLE, HOLD_TER:
                begin
                    pre_cnt_q <= 32'h0;
                end
                HOLD_PRI, HOLD_SEC:
                begin
                    pre_cnt_q <= sec_tick ? 32'h0 : pre_cnt_q + 32'h1;
                    if (sec_tick)
                        sec_cnt_q <= sec_cnt_q + 5'h1;
                    if (sec_fire)
                        hold_q <= HOLD_SEC;
                    if (ter_fire)
                        hold_q <= HOLD_TER;
                end
            endcase
        end
    end

    // Request decode; code 11 falls through to no action
    always_comb
    begin
        on_d = 1'b0;
        off_d = 1'b0;
        sec_irq_d = 1'b0;
        if (press)
        begin
            on_d = button_primary_action == ACT_ON;
            off_d = button_primary_action == ACT_OFF;
        end
        if (sec_fire)
        begin
            sec_irq_d = button_secondary_action == ACT_ZERO;
            on_d = button_secondary_action == ACT_ON;
            off_d = button_secondary_action == ACT_OFF;
        end
        if (ter_fire)
            off_d = 1'b1;
    end

    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            on_req_q <= 1'b0;
            off_req_q <= 1'b0;
        end
        else
        begin
            on_req_q <= on_d;
            off_req_q <= off_d;
        end
    end

    // Unlock and control fields
    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            unlocked_q <= 1'b0;
            timeout_q <= TO_RST;
            button_primary_action <= PRI_RST;
            button_secondary_action <= SEC_RST;
        end
        else if (wr_en)
        begin
            if (idx == IDX_SEC)
                unlocked_q <= pwdata[15:0] == UNLOCK_CODE;
            if (hit_ctrl && unlocked_q)
            begin
                timeout_q <= pwdata[CTRL_TO_LSB +: 2];
                button_primary_action <= pwdata[CTRL_PRI_LSB +: 2];
                button_secondary_action <= pwdata[CTRL_SEC_LSB +: 2];
            end
        end
    end

    // Masks
    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            button_edge_mask <= BTN_MASK_RST;
            {por_event_mask, sleep_off_event_mask, on_wake_event_mask}
                <= PS_MASK_RST;
        end
        else if (wr_en)
        begin
            if (idx == IDX_MASK1)
                button_edge_mask <= pwdata[BTN_FLAG_BIT];
            if (idx == IDX_MASK2)
            begin
                por_event_mask <= pwdata[POR_BIT];
                sleep_off_event_mask <= pwdata[SLPOFF_BIT];
                on_wake_event_mask <= pwdata[ONWAKE_BIT];
            end
        end
    end

    // Sticky flags; a set in the clearing cycle wins
    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            on_prev_q <= 1'b0;
            slpoff_prev_q <= 1'b0;
            por_prev_q <= 1'b0;
            button_edge_flag <= 1'b0;
            por_event_flag <= 1'b0;
            sleep_off_event_flag <= 1'b0;
            on_wake_event_flag <= 1'b0;
        end
        else
        begin
            on_prev_q <= state_on;
            slpoff_prev_q <= state_sleep | state_off;
            por_prev_q <= por_event;
            if (press || release_ev || sec_irq_d)
                button_edge_flag <= 1'b1;
            else if (wr_en && hit_stat1 && pwdata[BTN_FLAG_BIT])
                button_edge_flag <= 1'b0;
            if (por_event && !por_prev_q)
                por_event_flag <= 1'b1;
            else if (wr_en && hit_stat2 && pwdata[POR_BIT])
                por_event_flag <= 1'b0;
            if ((state_sleep | state_off) && !slpoff_prev_q)
                sleep_off_event_flag <= 1'b1;
            else if (wr_en && hit_stat2 && pwdata[SLPOFF_BIT])
                sleep_off_event_flag <= 1'b0;
            if (state_on && !on_prev_q)
                on_wake_event_flag <= 1'b1;
            else if (wr_en && hit_stat2 && pwdata[ONWAKE_BIT])
                on_wake_event_flag <= 1'b0;
        end
    end

    // OFF source: pending button OFF is resolved at the next OFF entry
    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            off_prev_q <= 1'b0;
            btn_off_pend_q <= 1'b0;
            offsrc_btn_q <= 1'b0;
        end
        else
        begin
            off_prev_q <= state_off;
            if (state_off && !off_prev_q)
            begin
                offsrc_btn_q <= btn_off_pend_q | off_req_q;
                btn_off_pend_q <= 1'b0;
            end
            else if (off_req_q)
                btn_off_pend_q <= 1'b1;
        end
    end

    // Interrupt and indicator outputs
    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            ps_irq_q <= 1'b0;
            btn_irq_q <= 1'b0;
            gpio_on_q <= 1'b0;
            gpio_sleep_q <= 1'b0;
        end
        else
        begin
            ps_irq_q <= (por_event_flag & ~por_event_mask) |
                (sleep_off_event_flag & ~sleep_off_event_mask) |
                (on_wake_event_flag & ~on_wake_event_mask);
            btn_irq_q <= button_edge_flag & ~button_edge_mask;
            gpio_on_q <= state_on;
            gpio_sleep_q <= state_sleep;
        end
    end

    always_comb
    begin
        rd_val = 32'h0;
        if (hit_ctrl)
        begin
            rd_val[CTRL_TO_LSB +: 2] = timeout_q;
            rd_val[CTRL_STS_BIT] = btn_db_q;
            rd_val[CTRL_PRI_LSB +: 2] = button_primary_action;
            rd_val[CTRL_SEC_LSB +: 2] = button_secondary_action;
        end
        else if (idx == IDX_SEC)
            rd_val[0] = unlocked_q;
        else if (idx == IDX_OFFSRC)
            rd_val[OFFSRC_BTN_BIT] = offsrc_btn_q;
        else if (hit_stat1)
            rd_val[BTN_FLAG_BIT] = button_edge_flag;
        else if (hit_stat2)
        begin
            rd_val[POR_BIT] = por_event_flag;
            rd_val[SLPOFF_BIT] = sleep_off_event_flag;
            rd_val[ONWAKE_BIT] = on_wake_event_flag;
        end
        else if (idx == IDX_MASK1)
            rd_val[BTN_FLAG_BIT] = button_edge_mask;
        else if (idx == IDX_MASK2)
        begin
            rd_val[POR_BIT] = por_event_mask;
            rd_val[SLPOFF_BIT] = sleep_off_event_mask;
            rd_val[ONWAKE_BIT] = on_wake_event_mask;
        end
    end

    // APB: one wait state, so read data and error come from flops
    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q <= 32'h0;
        end
        else
        begin
            pready_q <= access & ~pready_q;
            pslverr_q <= access & ~pready_q & ~mapped;
            if (access && !pready_q && !pwrite && mapped)
                prdata_q <= rd_val;
            else if (access && !pready_q)
                prdata_q <= 32'h0;
        end
    end

    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;
    assign on_req = on_req_q;
    assign off_req = off_req_q;
    assign power_state_irq = ps_irq_q;
    assign button_irq = btn_irq_q;
    assign gpio_on_ind = gpio_on_q;
    assign gpio_sleep_ind = gpio_sleep_q;

endmodule

// [bench/pb_power_button_monitor.sv]
// Purpose: Port checks for the power button block
// Assumes: One clock, synchronous reset
// Notes: Unmask state is tracked from completed APB writes
`timescale 1ns/1ns
module pb_power_button_monitor
    import pb_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [16:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic button_n,
    input wire logic state_on,
    input wire logic state_sleep,
    input wire logic on_req,
    input wire logic off_req,
    input wire logic power_state_irq,
    input wire logic button_irq,
    input wire logic gpio_on_ind,
    input wire logic gpio_sleep_ind
);
    logic m1_q;
    logic m2_q;
    logic wr_ok;
    assign wr_ok = psel && penable && pready && pwrite;
    // Set once software clears a mask bit
    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            m1_q <= 1'b0;
            m2_q <= 1'b0;
        end
        else if (wr_ok)
        begin
            if (paddr[16:2] == IDX_MASK1 && !pwdata[12])
                m1_q <= 1'b1;
            if (paddr[16:2] == IDX_MASK2 && pwdata[2:0] != 3'h7)
                m2_q <= 1'b1;
        end
    end
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rst_n);
    on_pulse_a: assert property (on_req |=> !on_req)
        else $error("on request longer than one cycle");
    off_pulse_a: assert property (off_req |=> !off_req)
        else $error("off request longer than one cycle");
    on_ind_a: assert property (
        1'b1 |=> gpio_on_ind == $past(state_on))
        else $error("on indicator does not follow state");
    sleep_ind_a: assert property (
        1'b1 |=> gpio_sleep_ind == $past(state_sleep))
        else $error("sleep indicator does not follow state");
    ps_mask_a: assert property (!m2_q |-> !power_state_irq)
        else $error("state interrupt while all masked");
    btn_mask_a: assert property (!m1_q |-> !button_irq)
        else $error("button interrupt while masked");
    req_held_a: assert property (
        (on_req || off_req) |-> !$past(button_n, 2))
        else $error("request without held button");
    apb_wait_a: assert property (psel && penable && !pready |=> pready)
        else $error("access phase answer late");
    err_ready_a: assert property (pslverr |-> pready)
        else $error("error without ready");
    cover property (on_req);
    cover property (off_req);
    cover property ($rose(power_state_irq));
    cover property (pslverr);
endmodule

bind pb_power_button pb_power_button_monitor u_mon (.clk_sys, .rst_n,
    .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .pslverr,
    .button_n, .state_on, .state_sleep, .on_req, .off_req,
    .power_state_irq, .button_irq, .gpio_on_ind, .gpio_sleep_ind);

// [bench/pb_partner.sv]
// Purpose: Power switch and state sequencer stand-in
// Assumes: Requests arrive as one-cycle pulses
// Notes: slow delays every state change by five cycles
`timescale 1ns/1ns
module pb_partner
(
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic press,
    input wire logic slow,
    input wire logic go_sleep,
    input wire logic on_req,
    input wire logic off_req,
    output logic button_n,
    output logic state_on,
    output logic state_sleep,
    output logic state_off
);
    logic [1:0] pend_q;
    logic [2:0] cnt_q;
    // Pulled-up switch, shorted to ground while pressed
    assign button_n = !press;
    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            pend_q <= 2'h0;
            cnt_q <= 3'h0;
            state_on <= 1'b0;
            state_sleep <= 1'b0;
            state_off <= 1'b0;
        end
        else if (on_req || off_req || go_sleep)
        begin
            pend_q <= go_sleep ? 2'h3 : {off_req, on_req};
            cnt_q <= slow ? 3'h5 : 3'h0;
        end
        else if (cnt_q != 3'h0)
            cnt_q <= cnt_q - 3'h1;
        else if (pend_q != 2'h0)
        begin
            state_on <= pend_q == 2'h1;
            state_off <= pend_q == 2'h2;
            state_sleep <= pend_q == 2'h3;
            pend_q <= 2'h0;
        end
    end
endmodule

// [bench/pb_power_button_test.sv]
// Purpose: Self-checking bench for the power button block
// Assumes: One second shortened to 20 cycles, debounce to 4
// Notes: Request pulses are counted by a free-running monitor
`timescale 1ns/1ns
module pb_power_button_test;
    import pb_pkg::*;
    localparam int ONE = 20;
    logic clk_sys, rst_n, psel, penable, pwrite, pready, pslverr;
    logic [16:0] paddr;
    logic [31:0] pwdata, prdata;
    logic button_n, state_on, state_sleep, state_off, por_event;
    logic on_req, off_req, power_state_irq, button_irq;
    logic gpio_on_ind, gpio_sleep_ind, press, slow, go_sleep;
    int checks, n_mismatch, n_on, n_off, t_prev, t_last, cyc;
    pb_power_button #(.ONE_SEC_CYCLES(ONE), .DEB_CYCLES(4)) u_dut (
        .clk_sys, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .button_n, .state_on, .state_sleep,
        .state_off, .por_event, .on_req, .off_req, .power_state_irq,
        .button_irq, .gpio_on_ind, .gpio_sleep_ind);
    pb_partner u_ptn (.clk_sys, .rst_n, .press, .slow, .go_sleep,
        .on_req, .off_req, .button_n, .state_on, .state_sleep, .state_off);
    initial
    begin
        clk_sys = 1'b0;
        forever #10 clk_sys = !clk_sys;
    end
    always @(posedge clk_sys)
    begin
        cyc++;
        if (on_req === 1'b1)
            n_on++;
        if (off_req === 1'b1)
        begin
            n_off++;
            t_prev = t_last;
            t_last = cyc;
        end
    end
    task automatic stop_test;
        $display("checks %0d mismatches %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [14:0] i,
        input logic [31:0] d, output logic [31:0] r, output logic e);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {i, 2'b00};
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        @(posedge clk_sys);
        while (pready !== 1'b1)
        begin
            n++;
            if (n > 20)
            begin
                n_mismatch++;
                stop_test;
            end
            @(posedge clk_sys);
        end
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        // Idle edge so a following call never drives psel twice at once
        @(posedge clk_sys);
    endtask
    task automatic wr(input logic [14:0] i, input logic [31:0] d);
        logic [31:0] r;
        logic e;
        apb(1'b1, i, d, r, e);
    endtask
    task automatic rd(input logic [14:0] i, input logic [31:0] x);
        logic [31:0] r;
        logic e;
        apb(1'b0, i, 32'h0, r, e);
        check(r, x);
    endtask
    task automatic hold(input int k);
        press <= 1'b1;
        repeat (k) @(posedge clk_sys);
        press <= 1'b0;
    endtask
    task automatic t_reset;
        logic [31:0] r;
        logic e;
        rd(IDX_CTRL, 32'h108);
        rd(IDX_MASK1, 32'h1000);
        rd(IDX_MASK2, 32'h7);
        rd(IDX_STAT2, 32'h0);
        apb(1'b0, 15'h0123, 32'h0, r, e);
        check(32'(e), 32'h1);
        $display("test reset done");
    endtask
    task automatic t_lock;
        wr(IDX_CTRL, 32'h0331);
        rd(IDX_CTRL, 32'h108);
        wr(IDX_SEC, {16'h0, UNLOCK_CODE});
        wr(IDX_CTRL, 32'h0330);
        rd(IDX_CTRL, 32'h338);
        n_on = 0;
        n_off = 0;
        hold(30);
        repeat (20) @(posedge clk_sys);
        check(32'(n_on + n_off), 32'h0);
        $display("test lock and reserved done");
    endtask
    task automatic t_button;
        wr(IDX_MASK1, 32'h0);
        wr(IDX_STAT1, 32'h1000);
        hold(2);
        repeat (10) @(posedge clk_sys);
        rd(IDX_STAT1, 32'h0);
        wr(IDX_CTRL, 32'h0021);
        n_off = 0;
        press <= 1'b1;
        repeat (10) @(posedge clk_sys);
        rd(IDX_CTRL, 32'h0021);
        rd(IDX_STAT1, 32'h1000);
        check(32'(button_irq), 32'h1);
        wr(IDX_STAT1, 32'h0);
        rd(IDX_STAT1, 32'h1000);
        wr(IDX_STAT1, 32'h1000);
        rd(IDX_STAT1, 32'h0);
        check(32'(button_irq), 32'h0);
        repeat (25) @(posedge clk_sys);
        rd(IDX_STAT1, 32'h1000);
        check(32'(n_off), 32'h1);
        wr(IDX_STAT1, 32'h1000);
        press <= 1'b0;
        repeat (10) @(posedge clk_sys);
        rd(IDX_STAT1, 32'h1000);
        repeat (100) @(posedge clk_sys);
        check(32'(n_off), 32'h1);
        rd(IDX_OFFSRC, 32'h10);
        $display("test button done");
    endtask
    task automatic t_timeout;
        int n;
        for (int c = 0; c < 4; c++)
        begin
            wr(IDX_CTRL, 32'h0210 | 32'(c));
            slow <= c[0];
            n_on = 0;
            n_off = 0;
            n = 0;
            press <= 1'b1;
            while (n_off < 2)
            begin
                @(posedge clk_sys);
                n++;
                if (n > 500)
                begin
                    n_mismatch++;
                    stop_test;
                end
            end
            press <= 1'b0;
            check(32'(t_last - t_prev), 32'((1 << c) * ONE));
            repeat (30) @(posedge clk_sys);
            check(32'(n_on), 32'h1);
            check(32'(n_off), 32'h2);
        end
        $display("test timeouts done");
    endtask
    task automatic t_state;
        slow <= 1'b0;
        wr(IDX_STAT2, 32'h7);
        wr(IDX_MASK2, 32'h6);
        wr(IDX_CTRL, 32'h0310);
        hold(12);
        repeat (20) @(posedge clk_sys);
        check(32'(gpio_on_ind), 32'h1);
        rd(IDX_STAT2, 32'h1);
        check(32'(power_state_irq), 32'h1);
        wr(IDX_STAT2, 32'h1);
        repeat (2) @(posedge clk_sys);
        check(32'(power_state_irq), 32'h0);
        go_sleep <= 1'b1;
        @(posedge clk_sys);
        go_sleep <= 1'b0;
        repeat (20) @(posedge clk_sys);
        check(32'(gpio_sleep_ind), 32'h1);
        rd(IDX_STAT2, 32'h2);
        check(32'(power_state_irq), 32'h0);
        por_event <= 1'b1;
        repeat (5) @(posedge clk_sys);
        rd(IDX_STAT2, 32'h6);
        por_event <= 1'b0;
        wr(IDX_CTRL, 32'h0100);
        n_on = 0;
        n_off = 0;
        hold(30);
        repeat (20) @(posedge clk_sys);
        check(32'(n_on), 32'h1);
        check(32'(n_off), 32'h0);
        rd(IDX_STAT2, 32'h7);
        $display("test state flags done");
    endtask
    initial
    begin
        rst_n = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 17'h0;
        pwdata = 32'h0;
        press = 1'b0;
        slow = 1'b0;
        go_sleep = 1'b0;
        por_event = 1'b0;
        repeat (8) @(posedge clk_sys);
        rst_n <= 1'b1;
        t_reset;
        t_lock;
        t_button;
        t_timeout;
        t_state;
        stop_test;
    end
endmodule
